// ===== bench/bel_bus_model.sv
`timescale 1ns/10ps
module bel_bus_model
    import bel_pkg::*;
(
    input  wire logic pclk,
    output      bel_bus_t bus,
    output      bel_err_t err
);
    integer seed = 32'hf783b88c;
    initial begin
        bus = '0;
        err = '0;
    end
    function automatic logic [6:0] code(input logic [31:0] d);
        logic [6:0] s;
        s = 7'h00;
        for (int i = 0; i < 32; i++) begin
            if (d[i]) s ^= BEL_SYN_TBL[i];
        end
        return s;
    endfunction : code
    // command cycle, then nb beats; beat eb carries the flips
    task automatic xfer(input logic [38:0] c, input logic [6:0] sd, input logic [3:0] ev,
                        input int nb, input int eb, input logic [127:0] df,
                        input logic [27:0] ef);
        logic [127:0] d;
        logic [27:0]  e;
        @(posedge pclk);
        bus <= {2'b10, 89'h0, c, 28'h0, sd};
        err <= ev;
        for (int k = 0; k < nb; k++) begin
            d = {$random(seed), $random(seed), $random(seed), $random(seed)};
            e = {code(d[127:96]), code(d[95:64]), code(d[63:32]), code(d[31:0])};
            if (k == eb) begin
                d = d ^ df;
                e = e ^ ef;
            end
            @(posedge pclk);
            bus <= {2'b01, d, e, 7'h0};
            err <= '0;
        end
        @(posedge pclk);
        bus <= {2'b00, ~bus.data, bus.ecc, 7'h0};
        err <= '0;
    endtask : xfer
endmodule : bel_bus_model

// ===== bench/bel_logger_monitor.sv
`timescale 1ns/10ps
module bel_logger_monitor
    import bel_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [BEL_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire bel_bus_t          bus_in,
    input wire bel_err_t          err_in,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    logic        armed_reg;
    logic        held_reg;
    logic [38:0] cap_reg;
    wire rd = pready && !pwrite;
    wire map = paddr inside {BEL_OFF_SYN0, BEL_OFF_SYN1, BEL_OFF_SYN2, BEL_OFF_SYN3,
                             BEL_OFF_LOG_LO, BEL_OFF_LOG_HI, BEL_OFF_FLAGS};
    wire clr = pready && pwrite && paddr == BEL_OFF_FLAGS && pwdata[7:0] == 8'hff;
    // first data or error cycle since the log was last cleared; held only if it was a command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b1;
            held_reg  <= 1'b0;
            cap_reg   <= '0;
        end else if (clr) begin
            armed_reg <= 1'b1;
            held_reg  <= 1'b0;
        end else if (armed_reg && (bus_in.data_cycle || |err_in)) begin
            armed_reg <= 1'b0;
            held_reg  <= bus_in.cmd_cycle;
            cap_reg   <= bus_in.data[38:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_wait; psel && penable && !pready |-> ##1 pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse; $rose(pready) |=> $fell(pready); endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_quiet: assert property (p_quiet) else $error("idle outputs not zero");
    property p_unmap; pready |-> pslverr == !map && (map || prdata == 32'h0); endproperty
    a_unmap: assert property (p_unmap) else $error("slave error wrong");
    property p_syn; rd && paddr[11:8] == 4'h6 |-> prdata[31:7] == 25'h0; endproperty
    a_syn: assert property (p_syn) else $error("syndrome upper bits");
    property p_hi; rd && paddr == BEL_OFF_LOG_HI |-> !(|prdata[31:20]) && !(|prdata[14:11]);
    endproperty
    a_hi: assert property (p_hi) else $error("log high reserved bits");
    property p_lo; rd && paddr == BEL_OFF_LOG_LO && held_reg |-> prdata == cap_reg[31:0];
    endproperty
    a_lo: assert property (p_lo) else $error("log low wrong");
    property p_cmd; rd && paddr == BEL_OFF_LOG_HI && held_reg |-> prdata[6:0] == cap_reg[38:32];
    endproperty
    a_cmd: assert property (p_cmd) else $error("log command wrong");
    c_err: cover property (pready && pslverr);
    c_log: cover property (rd && paddr == BEL_OFF_LOG_LO && held_reg);
    c_clr: cover property (clr);
endmodule : bel_logger_monitor
bind bel_logger bel_logger_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .bus_in(bus_in),
    .err_in(err_in), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ===== bench/test_bus_error_capture_logger.sv
`timescale 1ns/10ps
module test_bus_error_capture_logger
    import bel_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    bel_bus_t    bus_in;
    bel_err_t    err_in;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    integer      seed = 32'hf783b88c;
    int          n_mismatch = 0;
    int          checks = 0;
    logic [11:0] syn [4] = '{BEL_OFF_SYN0, BEL_OFF_SYN1, BEL_OFF_SYN2, BEL_OFF_SYN3};
    logic [38:0] c;
    logic [6:0]  sd;
    int          ln, b, b2, n, i;
    initial forever #2 pclk = ~pclk;
    bel_logger dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .bus_in(bus_in), .err_in(err_in),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bel_bus_model mdl (.pclk(pclk), .bus(bus_in), .err(err_in));
    task automatic complete_run;
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [31:0] e, input logic ee);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            complete_run();
        end
        if (!w) chk("prdata", e, prdata);
        chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] loghi(input logic [1:0] bt);
        return {12'h0, bt, sd[2:0], 4'h0, sd[6:3], c[38:32]};
    endfunction : loghi
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) apb(0, syn[i], 0, 0, 0);
        apb(0, BEL_OFF_LOG_LO, 0, BEL_LOG_RST, 0);
        apb(0, 12'h7c0, 0, 0, 1);
        apb(1, BEL_OFF_SYN0, '1, 0, 0);
        apb(0, BEL_OFF_SYN0, 0, 0, 0);
        c  = {$random(seed), $random(seed)};
        sd = 7'($random(seed));
        ln = $random(seed) & 3;
        b  = $random(seed) & 31;
        mdl.xfer(c, sd, 4'h0, 2, 1, 128'h1 << (32 * ln + b), 28'h0);
        for (i = 0; i < 4; i++) apb(0, syn[i], 0, (i == ln) ? BEL_SYN_TBL[b] : 0, 0);
        apb(0, BEL_OFF_LOG_LO, 0, c[31:0], 0);
        apb(0, BEL_OFF_LOG_HI, 0, loghi(2'h1), 0);
        apb(0, BEL_OFF_FLAGS, 0, 32'h101, 0);
        mdl.xfer(~c, ~sd, 4'h0, 1, 0, 128'h0, 28'h8);
        apb(0, syn[ln], 0, BEL_SYN_TBL[b], 0);
        apb(0, BEL_OFF_LOG_LO, 0, c[31:0], 0);
        apb(0, BEL_OFF_FLAGS, 0, 32'h105, 0);
        apb(1, BEL_OFF_FLAGS, 32'hff, 0, 0);
        apb(0, BEL_OFF_FLAGS, 0, 0, 0);
        b2 = (b + 5) & 31;
        n  = b % 7;
        mdl.xfer(c, sd, 4'h0, 4, 3, (128'h1 << (32 * ln + b)) | (128'h1 << (32 * ln + b2)),
                 28'h1 << (7 * ((ln + 1) & 3) + n));
        for (i = 0; i < 4; i++)
            apb(0, syn[i], 0, (i == ln) ? BEL_SYN_TBL[b] ^ BEL_SYN_TBL[b2] :
                (i == ((ln + 1) & 3)) ? 32'h1 << n : 0, 0);
        apb(0, BEL_OFF_LOG_HI, 0, loghi(2'h3), 0);
        apb(0, BEL_OFF_FLAGS, 0, 32'h102, 0);
        apb(1, BEL_OFF_FLAGS, 32'hff, 0, 0);
        for (i = 0; i < 8; i++) begin
            c        = {$random(seed), $random(seed)};
            c[37:35] = i[2:0];
            sd       = 7'($random(seed));
            mdl.xfer(c, sd, 4'h8 >> (i % 4), 0, 0, 128'h0, 28'h0);
            apb(0, BEL_OFF_LOG_LO, 0, c[31:0], 0);
            apb(0, BEL_OFF_LOG_HI, 0, loghi(2'h0), 0);
            apb(0, BEL_OFF_FLAGS, 0, 32'h100 | (32'h10 << (i % 4)), 0);
            apb(1, BEL_OFF_FLAGS, 32'hff, 0, 0);
        end
        complete_run();
    end
endmodule : test_bus_error_capture_logger

// ===== core/bel_logger.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps

// What this block does
// RL1 - syndrome is regenerated check code xor received check field
// RL2 - syndrome registers capture only on first ecc error, then hold
// RL3 - later ecc errors set repeat flags until software clears them
// RL4 - syndrome 0 from data 31:0 and check 6:0, upper bits zero
// RL5 - syndrome 1 from data 63:32/check 13:7, syndrome 2 third word/check 20:14
// RL6 - syndrome 3 from data 127:96 and check 27:21
// RL7 - zero syndrome means the longword has no ecc error
// RL8 - single data bit errors map to the fixed syndrome table
// RL9 - single check bit n error gives syndrome with only bit n
// RL10 - any other nonzero syndrome is an uncorrectable double error
// RL11 - on error latch that command cycle into the command log
// RL12 - log low word holds data 31:0 of the command cycle
// RL13 - log high bits 19:18 give failing data beat 0 to 3
// RL14 - bits 17 and 16 record dirty and shared for the command
// RL15 - bit 15 records confirmation; bits 31:20 and 14:11 read zero
// RL16 - bits 10:7 hold requester identity of the command
// RL17 - bit 6 holds command parity line 38
// RL18 - bits 5:3 hold command code lines 37:35
// RL19 - bits 2:0 hold upper command/address lines 34:32
// RL20 - log locks on ecc, parity, nonexistent address, arbitration drop
// RL21 - locked log holds until software clears the causing flags
module bel_logger
    import bel_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [BEL_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire bel_bus_t          bus_in,
    input  wire bel_err_t          err_in,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr
);

    // regenerated check code of one longword
    function automatic logic [6:0] bel_check(input logic [31:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 32; i++) begin
            if (d[i]) begin
                c = c ^ BEL_SYN_TBL[i]; // [RL8]
            end
        end
        return c;
    endfunction : bel_check

    // true when syndrome names exactly one failing bit
    function automatic logic bel_single(input logic [6:0] s);
        logic hit;
        hit = $onehot(s); // [RL9]
        for (int i = 0; i < 32; i++) begin
            if (s == BEL_SYN_TBL[i]) begin
                hit = 1'b1; // [RL8]
            end
        end
        return hit;
    endfunction : bel_single

    function automatic logic bel_mapped(input logic [BEL_AW-1:0] a);
        return (a == BEL_OFF_SYN0)   || (a == BEL_OFF_SYN1)
            || (a == BEL_OFF_SYN2)   || (a == BEL_OFF_SYN3)
            || (a == BEL_OFF_LOG_LO) || (a == BEL_OFF_LOG_HI)
            || (a == BEL_OFF_FLAGS);
    endfunction : bel_mapped

    logic [BEL_LANES-1:0][6:0] synd;
    logic [BEL_LANES-1:0]      lane_err;
    logic [BEL_LANES-1:0]      lane_dbl;
    logic [BEL_LANES-1:0][6:0] syn_reg;
    logic [7:0]                flags_reg;
    logic [7:0]                flags_next;
    logic [7:0]                flags_set;
    logic [7:0]                flags_clr;
    logic                      lock_reg;
    logic                      lock_next;
    logic [31:0]               log_lo_reg;
    logic [31:0]               log_hi_reg;
    logic [38:0]               cmd_hold_reg;
    logic [3:0]                req_hold_reg;
    logic                      dirty_hold_reg;
    logic                      shared_hold_reg;
    logic                      confirm_hold_reg;
    logic [1:0]                beat_reg;
    logic                      ecc_event;
    logic                      uce_event;
    logic                      ce_event;
    logic                      first_busy;
    logic                      other_event;
    logic                      lock_cause;
    logic [38:0]               log_cmd;
    logic [3:0]                log_req;
    logic                      log_dirty;
    logic                      log_shared;
    logic                      log_confirm;
    logic [1:0]                log_beat;
    logic                      syn_take;
    logic                      log_take;
    logic                      apb_take;
    logic                      apb_done;
    logic [31:0]               rd_mux;

    // per-lane syndrome and classification
    for (genvar g = 0; g < BEL_LANES; g++) begin : g_lane
        assign synd[g] = bel_check(bus_in.data[g*32 +: 32])
                       ^ bus_in.ecc[g*BEL_SW +: BEL_SW];  // [RL1] [RL4] [RL5] [RL6]
        assign lane_err[g] = (synd[g] != 7'h00);          // [RL7]
        assign lane_dbl[g] = lane_err[g] && !bel_single(synd[g]); // [RL10]
    end

    // only data beats carry check bits; command cycles are never ecc checked
    // a double error in any lane makes the whole beat uncorrectable
    assign ecc_event  = bus_in.data_cycle && (|lane_err);
    assign uce_event  = ecc_event && (|lane_dbl);
    assign ce_event   = ecc_event && !uce_event;
    assign first_busy = flags_reg[BEL_F_CE] || flags_reg[BEL_F_UCE];

    assign other_event = err_in.cmd_parity || err_in.csr_parity
                      || err_in.nxm || err_in.arb_drop;
    assign lock_cause  = ecc_event || other_event; // [RL20]

    // flag set and clear; a set in the clear cycle wins
    always_comb begin
        flags_set                = 8'h00;
        flags_set[BEL_F_CE]      = ce_event  && !first_busy;
        flags_set[BEL_F_UCE]     = uce_event && !first_busy;
        flags_set[BEL_F_CE2]     = ce_event  && first_busy;  // [RL3]
        flags_set[BEL_F_UNCORRECTABLE_REPEAT_FLAG]    = uce_event && first_busy;  // [RL3]
        flags_set[BEL_F_CPAR]    = err_in.cmd_parity;
        flags_set[BEL_F_CSRPAR]  = err_in.csr_parity;
        flags_set[BEL_F_NXM]     = err_in.nxm;
        flags_set[BEL_F_ARBDROP] = err_in.arb_drop;
    end

    assign apb_done  = psel && penable && pready;
    assign flags_clr = (apb_done && pwrite && (paddr == BEL_OFF_FLAGS))
                     ? pwdata[7:0] : 8'h00;
    assign flags_next = (flags_reg & ~flags_clr) | flags_set; // [RL3]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= BEL_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // syndromes freeze while a first-error flag stands
    assign syn_take = ecc_event && !first_busy;

    for (genvar g = 0; g < BEL_LANES; g++) begin : g_syn
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                syn_reg[g] <= BEL_SYN_RST;
            end else if (syn_take) begin
                syn_reg[g] <= synd[g]; // [RL2]
            end
        end
    end

    // data beat counter, restarted by each command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beat_reg <= BEL_BEAT_RST;
        end else if (bus_in.cmd_cycle) begin
            beat_reg <= BEL_BEAT_RST;
        end else if (bus_in.data_cycle && (beat_reg != BEL_BEAT_LAST)) begin
            beat_reg <= beat_reg + 2'h1;
        end
    end

    // command fields of the current command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_hold_reg <= 39'h0;
            req_hold_reg <= 4'h0;
        end else if (bus_in.cmd_cycle) begin
            cmd_hold_reg <= bus_in.data[38:0];
            req_hold_reg <= bus_in.req;
        end
    end

    // dirty line seen since the command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dirty_hold_reg <= 1'b0;
        end else if (bus_in.cmd_cycle) begin
            dirty_hold_reg <= bus_in.dirty;
        end else begin
            dirty_hold_reg <= dirty_hold_reg || bus_in.dirty;
        end
    end

    // shared line seen since the command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_hold_reg <= 1'b0;
        end else if (bus_in.cmd_cycle) begin
            shared_hold_reg <= bus_in.shared;
        end else begin
            shared_hold_reg <= shared_hold_reg || bus_in.shared;
        end
    end

    // confirmation seen since the command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            confirm_hold_reg <= 1'b0;
        end else if (bus_in.cmd_cycle) begin
            confirm_hold_reg <= bus_in.confirm;
        end else begin
            confirm_hold_reg <= confirm_hold_reg || bus_in.confirm;
        end
    end

    // an error in the command cycle itself logs that cycle
    always_comb begin
        if (bus_in.cmd_cycle) begin
            log_cmd     = bus_in.data[38:0];
            log_req     = bus_in.req;
            log_dirty   = bus_in.dirty;
            log_shared  = bus_in.shared;
            log_confirm = bus_in.confirm;
        end else begin
            log_cmd     = cmd_hold_reg;
            log_req     = req_hold_reg;
            log_dirty   = dirty_hold_reg  || bus_in.dirty;
            log_shared  = shared_hold_reg || bus_in.shared;
            log_confirm = confirm_hold_reg || bus_in.confirm;
        end
        log_beat = (ecc_event && !bus_in.cmd_cycle) ? beat_reg : BEL_BEAT_RST;
    end

    // lock falls only once every causing flag is cleared
    always_comb begin
        lock_next = lock_reg;
        if (!lock_reg && lock_cause) begin
            lock_next = 1'b1; // [RL20]
        end else if (lock_reg && (flags_next == 8'h00)) begin
            lock_next = 1'b0; // [RL21]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // a locked log ignores every later error
    assign log_take = !lock_reg && lock_cause; // [RL11] [RL21]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_lo_reg <= BEL_LOG_RST;
        end else if (log_take) begin
            log_lo_reg <= log_cmd[31:0];            // [RL12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_hi_reg <= BEL_LOG_RST;
        end else if (log_take) begin
            log_hi_reg <= {12'h000,                 // [RL15]
                           log_beat,                // [RL13]
                           log_dirty,               // [RL14]
                           log_shared,              // [RL14]
                           log_confirm,             // [RL15]
                           4'h0,
                           log_req,                 // [RL16]
                           log_cmd[38],             // [RL17]
                           log_cmd[37:35],          // [RL18]
                           log_cmd[34:32]};         // [RL19]
        end
    end

    // read mux, reserved bits zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            BEL_OFF_SYN0:   rd_mux = {25'h0, syn_reg[0]}; // [RL4]
            BEL_OFF_SYN1:   rd_mux = {25'h0, syn_reg[1]};
            BEL_OFF_SYN2:   rd_mux = {25'h0, syn_reg[2]};
            BEL_OFF_SYN3:   rd_mux = {25'h0, syn_reg[3]};
            BEL_OFF_LOG_LO: rd_mux = log_lo_reg;
            BEL_OFF_LOG_HI: rd_mux = log_hi_reg;
            BEL_OFF_FLAGS:  rd_mux = {23'h0, lock_reg, flags_reg};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait state, then a one-cycle registered answer
    assign apb_take = psel && penable && !pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_take;
        end
    end

    // read data only in the answer cycle, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_take && !pwrite) begin
            prdata <= rd_mux;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // unmapped offsets answer with a slave error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= apb_take && !bel_mapped(paddr);
        end
    end

endmodule : bel_logger

// ===== core/bel_pkg.sv
package bel_pkg;

    localparam int          BEL_AW          = 12;
    localparam int          BEL_LANES       = 4;
    localparam int          BEL_SW          = 7;

    localparam logic [11:0] BEL_OFF_SYN0    = 12'h600;
    localparam logic [11:0] BEL_OFF_SYN1    = 12'h640;
    localparam logic [11:0] BEL_OFF_SYN2    = 12'h680;
    localparam logic [11:0] BEL_OFF_SYN3    = 12'h6c0;
    localparam logic [11:0] BEL_OFF_LOG_LO  = 12'h700;
    localparam logic [11:0] BEL_OFF_LOG_HI  = 12'h740;
    localparam logic [11:0] BEL_OFF_FLAGS   = 12'h780;

    localparam logic [6:0]  BEL_SYN_RST     = 7'h00;
    localparam logic [31:0] BEL_LOG_RST     = 32'h0000_0000;
    localparam logic [7:0]  BEL_FLAGS_RST   = 8'h00;
    localparam logic [1:0]  BEL_BEAT_RST    = 2'h0;
    localparam logic [1:0]  BEL_BEAT_LAST   = 2'h3;

    // bus error flag positions
    localparam int          BEL_F_CE        = 0;
    localparam int          BEL_F_UCE       = 1;
    localparam int          BEL_F_CE2       = 2;
    localparam int          BEL_F_UNCORRECTABLE_REPEAT_FLAG      = 3;
    localparam int          BEL_F_CPAR      = 4;
    localparam int          BEL_F_CSRPAR    = 5;
    localparam int          BEL_F_NXM       = 6;
    localparam int          BEL_F_ARBDROP   = 7;

    // syndrome of a single error in data bit i, entry i
    localparam logic [31:0][6:0] BEL_SYN_TBL = {
        7'h75, 7'h70, 7'h6d, 7'h6b, 7'h68, 7'h67, 7'h64, 7'h62,
        7'h1c, 7'h1a, 7'h19, 7'h16, 7'h15, 7'h13, 7'h0b, 7'h0e,
        7'h34, 7'h31, 7'h2c, 7'h2a, 7'h29, 7'h26, 7'h25, 7'h23,
        7'h5d, 7'h5b, 7'h58, 7'h57, 7'h54, 7'h52, 7'h4a, 7'h4f
    };

    typedef enum logic [2:0] {
        BEL_CMD_READ     = 3'b000,
        BEL_CMD_WRITE    = 3'b001,
        BEL_CMD_RSVD2    = 3'b010,
        BEL_CMD_VICTIM   = 3'b011,
        BEL_CMD_CSR_RD   = 3'b100,
        BEL_CMD_CSR_WR   = 3'b101,
        BEL_CMD_RSVD6    = 3'b110,
        BEL_CMD_PRIVATE  = 3'b111
    } bel_cmd_t;

    typedef struct packed {
        logic         cmd_cycle;
        logic         data_cycle;
        logic [127:0] data;
        logic [27:0]  ecc;
        logic [3:0]   req;
        logic         dirty;
        logic         shared;
        logic         confirm;
    } bel_bus_t;

    typedef struct packed {
        logic cmd_parity;
        logic csr_parity;
        logic nxm;
        logic arb_drop;
    } bel_err_t;

endpackage : bel_pkg
